// ===== inc/sqs_pkg.sv
// sqs_pkg: constants for the global qos / storm / switch-mii register bank.
// assumes a 25 MHz pclk and APB with 32-bit data; registers use the low byte.
package sqs_pkg;

  // register indexes; byte address is four times the index
  localparam logic [7:0]  IDX_QUEUE_SCHED_MIRROR = 8'h05;
  localparam logic [7:0]  IDX_MII_LINK_STORM_HI  = 8'h06;
  localparam logic [7:0]  IDX_STORM_THRESHOLD_LO = 8'h07;
  localparam logic [7:0]  IDX_STORM_PORT_CTRL    = 8'h20;
  localparam logic [7:0]  IDX_STORM_PORT_STATUS  = 8'h21;
  localparam int          ADDR_LSB               = 2;

  // queue_sched_mirror_ctrl fields
  localparam int          SCHED_MSB              = 3;
  localparam int          SCHED_LSB              = 2;
  localparam int          MIRROR_AND_BIT         = 0;
  localparam logic [7:0]  QSM_RESET              = 8'h00;
  localparam logic [7:0]  QSM_WMASK              = 8'hFF;

  // mii_link_storm_hi_ctrl fields
  localparam int          BACKPRESSURE_BIT       = 7;
  localparam int          HALF_DUPLEX_BIT        = 6;
  localparam int          PAUSE_BIT              = 5;
  localparam int          SLOW_SPEED_BIT         = 4;
  localparam int          NULL_VID_BIT           = 3;
  localparam int          THR_HI_MSB             = 2;
  localparam logic [7:0]  MLS_RESET              = 8'h00;

  // storm threshold
  localparam logic [7:0]  THR_LO_RESET           = 8'h4A;
  localparam int          THR_W                  = 11;

  // storm port control: per-port enables and multicast exclusion
  localparam int          NPORT                  = 5;
  localparam int          MC_EXCL_BIT            = 7;
  localparam logic [7:0]  SPC_RESET              = 8'h80;

  // scheduling modes and interleave ratios
  localparam logic [1:0]  SCHED_STRICT           = 2'b00;
  localparam logic [1:0]  SCHED_10_1             = 2'b01;
  localparam logic [1:0]  SCHED_5_1              = 2'b10;
  localparam logic [1:0]  SCHED_2_1              = 2'b11;
  localparam logic [3:0]  RATIO_10               = 4'hA;
  localparam logic [3:0]  RATIO_5                = 4'h5;
  localparam logic [3:0]  RATIO_2                = 4'h2;

  // storm windows
  localparam int          CLK_HZ                 = 25_000_000;
  localparam int          WIN_FAST_MS            = 50;
  localparam int          WIN_SLOW_MS            = 500;
  localparam int          WIN_FAST_CYC           = CLK_HZ / 1000 * WIN_FAST_MS;
  localparam int          WIN_SLOW_CYC           = CLK_HZ / 1000 * WIN_SLOW_MS;
  localparam int          WIN_CNT_W              = 24;

endpackage

// ===== hdl/sqs_storm_port.sv
// sqs_storm_port: one ingress port's broadcast-storm block counter.
// assumes per-frame strobes from the port's receive path, all on pclk.
`timescale 1ns/1ps
module sqs_storm_port
  import sqs_pkg::*;
(
  input  wire logic             pclk,       // clock
  input  wire logic             presetn,    // async reset, low
  input  wire logic             enable,     // storm limiting on for port
  input  wire logic             mc_excl,    // count broadcast only
  input  wire logic [THR_W-1:0] threshold,  // blocks per window
  input  wire logic             win_tick,   // window boundary pulse
  input  wire logic             sof,        // frame start pulse
  input  wire logic             bcast,      // all-ones destination
  input  wire logic             mcast,      // multicast bit set
  input  wire logic             blk,        // one 64-byte block received
  output logic                  drop,       // current frame dropped
  output logic                  limiting    // count reached threshold
);

  logic [THR_W-1:0] blk_cnt;
  logic             storm_frame;
  logic             is_storm;

  assign is_storm = bcast | (mcast & ~mc_excl);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      storm_frame <= 1'b0;
      drop        <= 1'b0;
    end else if (sof) begin
      storm_frame <= enable & is_storm;
      drop        <= enable & is_storm & (blk_cnt >= threshold);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_cnt <= '0;
    end else if (win_tick) begin
      blk_cnt <= '0;
    end else if (blk && storm_frame && !drop && blk_cnt != {THR_W{1'b1}}) begin
      blk_cnt <= blk_cnt + THR_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limiting <= 1'b0;
    end else begin
      limiting <= enable & (blk_cnt >= threshold);
    end
  end

endmodule

// ===== hdl/sqs_global_ctrl.sv
// sqs_global_ctrl: global qos, mirror, switch-mii and storm control bank.
// assumes an APB master on pclk and receive/egress strobes on the same clock.
`timescale 1ns/1ps
module sqs_global_ctrl
  import sqs_pkg::*;
#(
  parameter int WIN_FAST = WIN_FAST_CYC,       // 50 ms in pclk cycles
  parameter int WIN_SLOW = WIN_SLOW_CYC        // 500 ms in pclk cycles
)(
  input  wire logic             pclk,          // clock, 25 MHz
  input  wire logic             presetn,       // async reset, low
  input  wire logic             psel,          // apb select
  input  wire logic             penable,       // apb access phase
  input  wire logic             pwrite,        // apb write
  input  wire logic [11:0]      paddr,         // apb byte address
  input  wire logic [31:0]      pwdata,        // apb write data
  output logic                  pready,        // apb ready
  output logic [31:0]           prdata,        // apb read data
  output logic                  pslverr,       // apb error, unmapped
  input  wire logic             duplex_strap_pin, // strap: half duplex
  input  wire logic             pause_strap_pin,  // strap: pause on
  input  wire logic             speed_strap_pin,  // strap: slow speed
  output logic                  mii_backpressure, // mii back pressure on
  output logic                  mii_half_duplex,  // mii half duplex
  output logic                  mii_pause_en,     // mii pause flow ctrl
  output logic                  mii_slow_speed,   // mii 10 Mbps
  input  wire logic             sched_req,     // egress slot free, pulse
  input  wire logic             hi_pend,       // high queue has frame
  input  wire logic             lo_pend,       // low queue has frame
  output logic                  grant_hi,      // send high frame, pulse
  output logic                  grant_lo,      // send low frame, pulse
  input  wire logic             mir_check,     // mirror check, pulse
  input  wire logic             mir_src_match, // source is monitored
  input  wire logic             mir_dst_match, // destination monitored
  output logic                  mir_hit,       // frame to be mirrored
  input  wire logic             tag_valid,     // received tag, pulse
  input  wire logic [11:0]      rx_vlan_ident, // received vlan ident
  input  wire logic [11:0]      port_vlan_ident, // ingress default ident
  output logic [11:0]           out_vlan_ident,  // resulting ident
  output logic                  out_tag_valid,   // ident valid, pulse
  input  wire logic [NPORT-1:0] port_slow_speed, // port runs 10 Mbps
  input  wire logic [NPORT-1:0] rx_sof,        // frame start per port
  input  wire logic [NPORT-1:0] rx_bcast,      // all-ones destination
  input  wire logic [NPORT-1:0] rx_mcast,      // multicast bit set
  input  wire logic [NPORT-1:0] rx_blk,        // 64-byte block per port
  output logic [NPORT-1:0]      storm_drop     // drop current frame
);

  logic [7:0]       queue_sched_mirror_ctrl;
  logic [7:0]       mii_link_storm_hi_ctrl;
  logic [7:0]       storm_threshold_lo;
  logic [7:0]       storm_port_ctrl;
  logic [NPORT-1:0] port_limiting;
  logic             strap_done;
  logic [7:0]       idx;
  logic             setup;
  logic             wr_en;
  logic             mapped;
  logic [7:0]       rd_mux;
  logic [THR_W-1:0] threshold;
  logic [WIN_CNT_W-1:0] fast_cnt;
  logic [WIN_CNT_W-1:0] slow_cnt;
  logic             fast_tick;
  logic             slow_tick;
  logic [3:0]       hi_cnt;
  logic [3:0]       ratio;
  logic             lo_turn;

  assign idx   = paddr[ADDR_LSB+7:ADDR_LSB];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    unique case (idx)
      IDX_QUEUE_SCHED_MIRROR: rd_mux = queue_sched_mirror_ctrl;
      IDX_MII_LINK_STORM_HI:  rd_mux = mii_link_storm_hi_ctrl;
      IDX_STORM_THRESHOLD_LO: rd_mux = storm_threshold_lo;
      IDX_STORM_PORT_CTRL:    rd_mux = storm_port_ctrl;
      IDX_STORM_PORT_STATUS:  rd_mux = {3'h0, port_limiting};
      default:                mapped = 1'b0;
    endcase
    if (paddr[ADDR_LSB-1:0] != 2'b00) begin
      mapped = 1'b0;
    end
    // upper address bits would otherwise alias the map
    if (paddr[11:ADDR_LSB+8] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // one wait-free access: answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
    end
  end

  // read data held until the next setup; errors read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite && mapped) begin
      prdata <= {24'h00_0000, rd_mux};
    end else if (setup) begin
      prdata <= 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queue_sched_mirror_ctrl <= QSM_RESET;
    end else if (wr_en && idx == IDX_QUEUE_SCHED_MIRROR) begin
      queue_sched_mirror_ctrl <= pwdata[7:0] & QSM_WMASK;
    end
  end

  // straps sampled once, first edge after reset release;
  // a write on that same edge wins over the strap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done <= 1'b0;
    end else begin
      strap_done <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_link_storm_hi_ctrl <= MLS_RESET;
    end else if (wr_en && idx == IDX_MII_LINK_STORM_HI) begin
      mii_link_storm_hi_ctrl <= pwdata[7:0];
    end else if (!strap_done) begin
      mii_link_storm_hi_ctrl[HALF_DUPLEX_BIT] <= duplex_strap_pin;
      mii_link_storm_hi_ctrl[PAUSE_BIT]       <= pause_strap_pin;
      mii_link_storm_hi_ctrl[SLOW_SPEED_BIT]  <= speed_strap_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      storm_threshold_lo <= THR_LO_RESET;
    end else if (wr_en && idx == IDX_STORM_THRESHOLD_LO) begin
      storm_threshold_lo <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      storm_port_ctrl <= SPC_RESET;
    end else if (wr_en && idx == IDX_STORM_PORT_CTRL) begin
      storm_port_ctrl <= {pwdata[MC_EXCL_BIT], 2'b00, pwdata[NPORT-1:0]};
    end
  end

  // mii link controls follow the register one cycle later
  // back pressure enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_backpressure <= 1'b0;
    end else begin
      mii_backpressure <= mii_link_storm_hi_ctrl[BACKPRESSURE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_half_duplex <= 1'b0;
    end else begin
      mii_half_duplex <= mii_link_storm_hi_ctrl[HALF_DUPLEX_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_pause_en <= 1'b0;
    end else begin
      mii_pause_en <= mii_link_storm_hi_ctrl[PAUSE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_slow_speed <= 1'b0;
    end else begin
      mii_slow_speed <= mii_link_storm_hi_ctrl[SLOW_SPEED_BIT];
    end
  end

  always_comb begin
    unique case (queue_sched_mirror_ctrl[SCHED_MSB:SCHED_LSB])
      SCHED_STRICT: ratio = 4'h0;
      SCHED_10_1:   ratio = RATIO_10;
      SCHED_5_1:    ratio = RATIO_5;
      SCHED_2_1:    ratio = RATIO_2;
    endcase
  end

  // strict mode never yields to low while high waits
  assign lo_turn = (ratio != 4'h0) && (hi_cnt >= ratio);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grant_hi <= 1'b0;
      grant_lo <= 1'b0;
      hi_cnt   <= 4'h0;
    end else begin
      grant_hi <= 1'b0;
      grant_lo <= 1'b0;
      if (sched_req) begin
        // low frame after ratio high frames
        if (hi_pend && !(lo_pend && lo_turn)) begin
          grant_hi <= 1'b1;
          if (hi_cnt < RATIO_10) begin
            hi_cnt <= hi_cnt + 4'h1;
          end
        end else if (lo_pend) begin
          grant_lo <= 1'b1;
          hi_cnt   <= 4'h0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mir_hit <= 1'b0;
    end else if (mir_check) begin
      if (queue_sched_mirror_ctrl[MIRROR_AND_BIT]) begin
        mir_hit <= mir_src_match & mir_dst_match;
      end else begin
        mir_hit <= mir_src_match | mir_dst_match;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_tag_valid <= 1'b0;
    end else begin
      out_tag_valid <= tag_valid;
    end
  end

  // ident held between tags so the egress side may read it late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_vlan_ident <= 12'h000;
    end else if (tag_valid) begin
      if (mii_link_storm_hi_ctrl[NULL_VID_BIT] && rx_vlan_ident == 12'h000) begin
        out_vlan_ident <= port_vlan_ident;
      end else begin
        out_vlan_ident <= rx_vlan_ident;
      end
    end
  end

  assign threshold = {mii_link_storm_hi_ctrl[THR_HI_MSB:0], storm_threshold_lo};

  // 50 ms and 500 ms window pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_cnt  <= '0;
      fast_tick <= 1'b0;
    end else if (fast_cnt == WIN_CNT_W'(WIN_FAST - 1)) begin
      fast_cnt  <= '0;
      fast_tick <= 1'b1;
    end else begin
      fast_cnt  <= fast_cnt + WIN_CNT_W'(1);
      fast_tick <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt  <= '0;
      slow_tick <= 1'b0;
    end else if (slow_cnt == WIN_CNT_W'(WIN_SLOW - 1)) begin
      slow_cnt  <= '0;
      slow_tick <= 1'b1;
    end else begin
      slow_cnt  <= slow_cnt + WIN_CNT_W'(1);
      slow_tick <= 1'b0;
    end
  end

  for (genvar p = 0; p < NPORT; p++) begin : g_port
    sqs_storm_port u_port (
      .pclk      (pclk),
      .presetn   (presetn),
      .enable    (storm_port_ctrl[p]),
      .mc_excl   (storm_port_ctrl[MC_EXCL_BIT]),
      .threshold (threshold),
      .win_tick  (port_slow_speed[p] ? slow_tick : fast_tick),
      .sof       (rx_sof[p]),
      .bcast     (rx_bcast[p]),
      .mcast     (rx_mcast[p]),
      .blk       (rx_blk[p]),
      .drop      (storm_drop[p]),
      .limiting  (port_limiting[p])
    );
  end

endmodule

// ===== dv/sqs_strap_model.sv
// sqs_strap_model: board straps on the switch mii receive lines.
// assumes the bank samples straps at the first edge after reset release.
`timescale 1ns/1ps
module sqs_strap_model #(
  parameter logic HALF  = 1'b0,  // pull-up fitted on duplex strap
  parameter logic PAUSE = 1'b0,  // pull-up fitted on pause strap
  parameter logic SLOW  = 1'b0   // pull-up fitted on speed strap
)(
  input  wire logic pclk,             // clock
  input  wire logic presetn,          // async reset, low
  output logic      duplex_strap_pin, // strap or receive data
  output logic      pause_strap_pin,  // strap or receive data
  output logic      speed_strap_pin   // strap or receive data
);
  logic [1:0] n;
  logic       t;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      n <= 2'h0;
    else if (n != 2'h3)
      n <= n + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      t <= 1'b0;
    else
      t <= ~t;
  end

  // pull-downs unless fitted
  // later the lines carry receive data, so a late sample shows up
  assign duplex_strap_pin = (n < 2'h2) ? HALF : t;
  assign pause_strap_pin  = (n < 2'h2) ? PAUSE : ~t;
  assign speed_strap_pin  = (n < 2'h2) ? SLOW : t;
endmodule

// ===== dv/sqs_global_ctrl_monitor.sv
// sqs_global_ctrl_monitor: port assertions for the global control bank.
// assumes apb on pclk; shadows only what software writes.
`timescale 1ns/1ps
module sqs_global_ctrl_monitor
  import sqs_pkg::*;
(
  input wire logic             pclk,             // clock
  input wire logic             presetn,          // reset, low
  input wire logic             psel,             // apb select
  input wire logic             penable,          // apb access
  input wire logic             pwrite,           // apb write
  input wire logic [11:0]      paddr,            // apb address
  input wire logic [31:0]      pwdata,           // apb data
  input wire logic             pready,           // apb ready
  input wire logic             pslverr,          // apb error
  input wire logic             mii_backpressure, // back pressure
  input wire logic             mii_half_duplex,  // half duplex
  input wire logic             sched_req,        // slot free
  input wire logic             hi_pend,          // high waiting
  input wire logic             lo_pend,          // low waiting
  input wire logic             grant_hi,         // high grant
  input wire logic             grant_lo,         // low grant
  input wire logic             mir_check,        // mirror check
  input wire logic             mir_src_match,    // source match
  input wire logic             mir_dst_match,    // dest match
  input wire logic             mir_hit,          // mirror result
  input wire logic             tag_valid,        // tag in
  input wire logic [11:0]      port_vlan_ident,  // default ident
  input wire logic [11:0]      rx_vlan_ident,    // ident in
  input wire logic [11:0]      out_vlan_ident,   // ident out
  input wire logic             out_tag_valid,    // ident valid
  input wire logic [NPORT-1:0] rx_sof,           // frame start
  input wire logic [NPORT-1:0] storm_drop        // frame dropped
);
  logic [1:0]       sch;
  logic             mand;
  logic             nvid;
  logic [NPORT-1:0] en;
  logic [3:0]       hc;
  wire              wr = psel & penable & pready & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sch  <= 2'h0;
      mand <= 1'b0;
      nvid <= 1'b0;
      en   <= '0;
    end else if (wr && paddr == 12'h014) begin
      sch  <= pwdata[3:2];
      mand <= pwdata[0];
    end else if (wr && paddr == 12'h018) begin
      nvid <= pwdata[3];
    end else if (wr && paddr == 12'h080) begin
      en <= pwdata[NPORT-1:0];
    end
  end

  // high grants since the last low one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hc <= 4'h0;
    else if (grant_lo)
      hc <= 4'h0;
    else if (grant_hi && hc != 4'hF)
      hc <= hc + 4'h1;
  end

  function automatic logic [3:0] rat(input logic [1:0] s);
    return (s == SCHED_10_1) ? RATIO_10 : (s == SCHED_5_1) ? RATIO_5 : RATIO_2;
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("apb access not ready after setup");
  chk_bad_align: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access without error");
  chk_strict_high: assert property (
    sched_req && hi_pend && sch == SCHED_STRICT |=> grant_hi && !grant_lo)
    else $error("strict mode did not grant high");
  chk_ratio_turn: assert property (
    sched_req && hi_pend && lo_pend && sch != SCHED_STRICT && !grant_hi && !grant_lo
    |=> grant_lo == (hc >= rat(sch))) else $error("interleave ratio broken");
  chk_mirror_and: assert property (mir_check && mand |=>
    mir_hit == ($past(mir_src_match) && $past(mir_dst_match))) else $error("and mirror wrong");
  chk_mirror_or: assert property (mir_check && !mand |=>
    mir_hit == ($past(mir_src_match) || $past(mir_dst_match))) else $error("or mirror wrong");
  chk_back_press: assert property (
    wr && paddr == 12'h018 && pwdata[7] |=> ##1 mii_backpressure)
    else $error("back pressure not applied");
  chk_full_duplex: assert property (
    wr && paddr == 12'h018 && !pwdata[6] |=> ##1 !mii_half_duplex)
    else $error("duplex not full");
  chk_null_ident: assert property (
    tag_valid && nvid && rx_vlan_ident == 12'h000
    |=> out_tag_valid && out_vlan_ident == $past(port_vlan_ident)) else $error("null ident kept");
  chk_storm_off: assert property (rx_sof[1] && !en[1] |=> !storm_drop[1])
    else $error("disabled port dropped a frame");

  cover property (sched_req && hi_pend && lo_pend ##1 grant_lo);
  cover property (mir_check ##1 mir_hit);
  cover property (rx_sof[0] ##1 storm_drop[0]);
endmodule

bind sqs_global_ctrl sqs_global_ctrl_monitor i_sqs_global_ctrl_monitor (.*);

// ===== dv/switch_global_qos_storm_ctrl_tb_top.sv
// switch_global_qos_storm_ctrl_tb_top: apb-driven checks of the bank.
// assumes short storm windows of 200 and 2000 cycles.
`timescale 1ns/1ps
module switch_global_qos_storm_ctrl_tb_top
  import sqs_pkg::*;
;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, er, d;
  logic [11:0]      paddr, rx_vlan_ident, port_vlan_ident, out_vlan_ident;
  logic [31:0]      pwdata, prdata, rd;
  logic             duplex_strap_pin, pause_strap_pin, speed_strap_pin;
  logic             mii_backpressure, mii_half_duplex, mii_pause_en, mii_slow_speed;
  logic             sched_req, hi_pend, lo_pend, grant_hi, grant_lo, tag_valid;
  logic             mir_check, mir_src_match, mir_dst_match, mir_hit, out_tag_valid;
  logic [NPORT-1:0] port_slow_speed, rx_sof, rx_bcast, rx_mcast, rx_blk, storm_drop;
  logic [1:0]       g;
  int               fails, checks_done, cyc, k;
  int               rt[4] = '{12, 10, 5, 2};

  sqs_strap_model #(.HALF(1'b1), .SLOW(1'b1)) i_sqs_strap_model (.*);
  sqs_global_ctrl #(.WIN_FAST(200), .WIN_SLOW(2000)) i_sqs_global_ctrl (.*);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task sreq(input logic h, input logic l);
    @(posedge pclk);
    sched_req <= 1'b1;
    hi_pend <= h;
    lo_pend <= l;
    @(posedge pclk);
    sched_req <= 1'b0;
    #1 g = {grant_hi, grant_lo};
  endtask

  task pulse_in(input int kind, input logic s, input logic t, input logic [11:0] v);
    @(posedge pclk);
    mir_check <= kind == 0;
    tag_valid <= kind == 1;
    mir_src_match <= s;
    mir_dst_match <= t;
    rx_vlan_ident <= v;
    @(posedge pclk);
    mir_check <= 1'b0;
    tag_valid <= 1'b0;
    #1;
  endtask

  task frame(input int p, input logic b, input logic m, input int nb);
    @(posedge pclk);
    rx_sof[p] <= 1'b1;
    rx_bcast[p] <= b;
    rx_mcast[p] <= m;
    @(posedge pclk);
    rx_sof[p] <= 1'b0;
    rx_blk[p] <= nb > 0;
    #1 d = storm_drop[p];
    repeat (nb) @(posedge pclk);
    rx_blk[p] <= 1'b0;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, sched_req, hi_pend, lo_pend} = '0;
    {mir_check, mir_src_match, mir_dst_match, tag_valid, paddr, pwdata} = '0;
    {port_slow_speed, rx_sof, rx_bcast, rx_mcast, rx_blk, rx_vlan_ident} = '0;
    port_vlan_ident = 12'h5A3;
    {fails, checks_done, cyc} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h014, 0);
    chk(rd, 32'h00);
    apb(0, 12'h018, 0);
    chk(rd, 32'h50);
    apb(0, 12'h01C, 0);
    chk(rd, 32'h4A);
    chk({28'h0, mii_backpressure, mii_half_duplex, mii_pause_en, mii_slow_speed}, 32'h5);
    apb(0, 12'h015, 0);
    chk(32'(er), 32'h1);
    apb(1, 12'h018, 32'hFFFF_FFA8);
    apb(0, 12'h018, 0);
    chk(rd, 32'hA8);
    #1 chk({28'h0, mii_backpressure, mii_half_duplex, mii_pause_en, mii_slow_speed}, 32'hA);
    for (int m = 0; m < 4; m++) begin
      apb(1, 12'h014, m << 2);
      sreq(0, 1);
      k = 0;
      for (int i = 0; i < 12; i++) begin
        sreq(1, 1);
        if (g === 2'b10 && k == i)
          k++;
      end
      chk(k, rt[m]);
    end
    for (int i = 0; i < 8; i++) begin
      apb(1, 12'h014, i[2]);
      pulse_in(0, i[1], i[0], 12'h000);
      chk(32'(mir_hit), i[2] ? i[1] & i[0] : i[1] | i[0]);
    end
    pulse_in(1, 0, 0, 12'h000);
    chk({19'h0, out_tag_valid, out_vlan_ident}, 32'h15A3);
    pulse_in(1, 0, 0, 12'h123);
    chk({19'h0, out_tag_valid, out_vlan_ident}, 32'h1123);
    apb(1, 12'h018, 32'hA0);
    pulse_in(1, 0, 0, 12'h000);
    chk({19'h0, out_tag_valid, out_vlan_ident}, 32'h1000);
    apb(1, 12'h01C, 32'h02);
    apb(1, 12'h080, 32'h81);
    frame(0, 1, 0, 3);
    frame(0, 1, 0, 0);
    // a window edge may fall between the two frames; retry once
    if (d !== 1'b1) begin
      frame(0, 1, 0, 3);
      frame(0, 1, 0, 0);
    end
    chk(32'(d), 32'h1);
    frame(0, 0, 1, 0);
    chk(32'(d), 32'h0);
    repeat (200) @(posedge pclk);
    frame(0, 1, 0, 0);
    chk(32'(d), 32'h0);
    // slow port: count must outlive a fast window; retry once past a slow edge
    @(posedge pclk);
    port_slow_speed[0] <= 1'b1;
    frame(0, 1, 0, 3);
    repeat (300) @(posedge pclk);
    frame(0, 1, 0, 0);
    if (d !== 1'b1) begin
      frame(0, 1, 0, 3);
      repeat (300) @(posedge pclk);
      frame(0, 1, 0, 0);
    end
    chk(32'(d), 32'h1);
    @(posedge pclk);
    port_slow_speed[0] <= 1'b0;
    apb(1, 12'h01C, 32'h00);
    apb(1, 12'h080, 32'h01);
    apb(0, 12'h084, 0);
    chk(rd, 32'h01);
    frame(1, 1, 0, 0);
    chk(32'(d), 32'h0);
    frame(0, 0, 1, 0);
    chk(32'(d), 32'h1);
    apb(1, 12'h018, 32'h01);
    frame(0, 1, 0, 0);
    chk(32'(d), 32'h0);
    end_of_test();
  end
endmodule
